//--- core/embs_pkg.sv
/*
  Constants for the external memory bus strobe generator.
  Assumes one clock tick per oscillator period.
*/
package embs_pkg;
  localparam int unsigned EMBS_OSC_PER_CYCLE = 12;
  localparam int unsigned EMBS_RST_CYCLES = 2;
  localparam logic [3:0] EMBS_PH_LAST = 4'hB;
  // Strobe windows inside a machine cycle, in oscillator periods
  localparam logic [3:0] EMBS_ALE0_ON = 4'h2;
  localparam logic [3:0] EMBS_ALE0_OFF = 4'h4;
  localparam logic [3:0] EMBS_ALE1_ON = 4'h8;
  localparam logic [3:0] EMBS_ALE1_OFF = 4'hA;
  localparam logic [3:0] EMBS_PF0_ON = 4'h6;
  localparam logic [3:0] EMBS_PF0_OFF = 4'h8;
  localparam logic [3:0] EMBS_PF1_ON = 4'h0;
  localparam logic [3:0] EMBS_PF1_OFF = 4'h2;
  localparam logic [3:0] EMBS_DS_ON = 4'h2;
  localparam logic [3:0] EMBS_DS_OFF = 4'hA;
  typedef enum logic [1:0] {EMBS_IDLE, EMBS_RD, EMBS_WR} embs_mode_e;
endpackage

//--- core/embs_rst_qual.sv
/*
  Reset qualifier: asserts internal reset after the pin has stayed high
  for a whole number of machine cycles. Pin assumed synchronous.
*/
`timescale 1ns/10ps
module embs_rst_qual #(
  parameter int unsigned HOLD = 24
)(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic reset_pin,
  output logic core_rst
);
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic next_core_rst;

  // Count continuous high time on the pin
  always_comb
  begin
    next_cnt = cnt;
    next_core_rst = core_rst;
    if (!reset_pin)
    begin
      next_cnt = '0;
      next_core_rst = 1'b0;
    end
    else if (cnt >= 6'(HOLD - 1))
      next_core_rst = 1'b1;
    else
      next_cnt = cnt + 6'h01;
  end

  // Registers
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt <= 6'h00;
      core_rst <= 1'b1;
    end
    else
    begin
      cnt <= next_cnt;
      core_rst <= next_core_rst;
    end
  end

  chk_rst_needs_hold: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(core_rst) |-> $past(reset_pin, HOLD))
    else $error("reset qualified too early");
endmodule

//--- core/embs_top.sv
/*
  External memory bus strobe generator: address latch, program fetch,
  data read and write strobes, paced by a twelve-period machine cycle.
  Assumes the CPU requests data moves with a one-cycle pulse near the
  end of a machine cycle; clock is the oscillator input.
*/
// Summary of operation
// - reset pin must stay high two machine cycles
// - address latch pulses each external access
// - latch strobe repeats at oscillator over six
// - one latch pulse dropped per data access
// - aux bit one limits latch to moves
// - fetch strobe twice per external cycle
// - two fetch strobes skipped per data access
// - no fetch strobe from internal memory
// - write strobe during external data writes
// - read strobe during external data reads
`timescale 1ns/10ps
module embs_top
  import embs_pkg::*;
#(
  parameter int unsigned OSC_PER_CYCLE = embs_pkg::EMBS_OSC_PER_CYCLE
)(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic reset_pin,
  input wire logic external_fetch_select,
  input wire logic fetch_internal,
  input wire logic aux_latch_off,
  input wire logic data_move_req,
  input wire logic data_move_write,
  output logic core_rst,
  output logic address_latch_strobe,
  output logic program_fetch_strobe_n,
  output logic data_read_strobe_n,
  output logic data_write_strobe_n,
  output logic machine_cycle_start
);
  import embs_pkg::*;

  logic [3:0] phase;
  logic [3:0] next_phase;
  embs_mode_e mode;
  embs_mode_e next_mode;
  logic pend_wr;
  logic pend;
  logic next_pend;
  logic next_pend_wr;
  logic next_ale;
  logic next_pf_n;
  logic next_rd_n;
  logic next_wr_n;
  logic next_mcs;
  logic ext_code;

  function automatic logic in_win(input logic [3:0] p, input logic [3:0] on,
                                  input logic [3:0] off);
    in_win = (p >= on) && (p < off);
  endfunction

  // Qualified reset from the pin
  embs_rst_qual #(.HOLD(EMBS_RST_CYCLES * OSC_PER_CYCLE)) i_embs_rst_qual (
    .clock(clock),
    .sys_rst(sys_rst),
    .reset_pin(reset_pin),
    .core_rst(core_rst)
  );

  // Low select pin or an address above internal code forces external fetch
  assign ext_code = !external_fetch_select || !fetch_internal;

  // Phase counter and data-cycle mode
  always_comb
  begin
    next_phase = (phase == EMBS_PH_LAST) ? 4'h0 : phase + 4'h1;
    next_mode = mode;
    next_pend = pend | data_move_req;
    next_pend_wr = data_move_req ? data_move_write : pend_wr;
    if (phase == EMBS_PH_LAST)
    begin
      if (pend)
      begin
        next_mode = pend_wr ? EMBS_WR : EMBS_RD;
        next_pend = data_move_req;
      end
      else
        next_mode = EMBS_IDLE;
    end
  end

  // Strobe outputs
  always_comb
  begin
    next_ale = 1'b0;
    next_pf_n = 1'b1;
    next_rd_n = 1'b1;
    next_wr_n = 1'b1;
    next_mcs = (next_phase == 4'h0);
    case (mode)
      EMBS_IDLE:
      begin
        // Two latch pulses per cycle: one sixth of oscillator rate
        if (!aux_latch_off)
          next_ale = in_win(next_phase, EMBS_ALE0_ON, EMBS_ALE0_OFF) ||
                     in_win(next_phase, EMBS_ALE1_ON, EMBS_ALE1_OFF);
        if (ext_code)
          next_pf_n = !(in_win(next_phase, EMBS_PF0_ON, EMBS_PF0_OFF) ||
                        in_win(next_phase, EMBS_PF1_ON, EMBS_PF1_OFF));
      end
      EMBS_RD, EMBS_WR:
      begin
        // First latch pulse carries the data address, second is dropped
        next_ale = in_win(next_phase, EMBS_ALE0_ON, EMBS_ALE0_OFF);
        // Both fetch strobes of this cycle are skipped
        next_pf_n = 1'b1;
        if (mode == EMBS_RD)
          next_rd_n = !in_win(next_phase, EMBS_DS_ON, EMBS_DS_OFF);
        else
          next_wr_n = !in_win(next_phase, EMBS_DS_ON, EMBS_DS_OFF);
      end
      default:
      begin
        next_ale = 1'b0;
      end
    endcase
    if (next_mode != mode)
    begin
      next_ale = 1'b0;
      next_pf_n = 1'b1;
      next_rd_n = 1'b1;
      next_wr_n = 1'b1;
    end
  end

  // Registers; all but phase and cycle start held idle while the qualified reset stands
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      phase <= 4'h0;
      mode <= EMBS_IDLE;
      pend <= 1'b0;
      pend_wr <= 1'b0;
      address_latch_strobe <= 1'b0;
      program_fetch_strobe_n <= 1'b1;
      data_read_strobe_n <= 1'b1;
      data_write_strobe_n <= 1'b1;
      machine_cycle_start <= 1'b0;
    end
    else if (core_rst)
    begin
      phase <= next_phase;
      mode <= EMBS_IDLE;
      pend <= 1'b0;
      pend_wr <= 1'b0;
      address_latch_strobe <= 1'b0;
      program_fetch_strobe_n <= 1'b1;
      data_read_strobe_n <= 1'b1;
      data_write_strobe_n <= 1'b1;
      machine_cycle_start <= next_mcs;
    end
    else
    begin
      phase <= next_phase;
      mode <= next_mode;
      pend <= next_pend;
      pend_wr <= next_pend_wr;
      address_latch_strobe <= next_ale;
      program_fetch_strobe_n <= next_pf_n;
      data_read_strobe_n <= next_rd_n;
      data_write_strobe_n <= next_wr_n;
      machine_cycle_start <= next_mcs;
    end
  end

  // Clocks since the last cycle start; the cycle-length check reads it
  // so that no long repetition has to be unrolled
  logic [3:0] mcs_gap;
  logic [3:0] next_mcs_gap;
  logic mcs_seen;
  logic next_mcs_seen;

  always_comb
  begin
    next_mcs_gap = machine_cycle_start ? 4'h0 : mcs_gap + 4'h1;
    next_mcs_seen = mcs_seen | machine_cycle_start;
  end

  // Registers of the cycle-length helper
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mcs_gap <= 4'h0;
      mcs_seen <= 1'b0;
    end
    else
    begin
      mcs_gap <= next_mcs_gap;
      mcs_seen <= next_mcs_seen;
    end
  end

  chk_cycle_twelve: assert property (@(posedge clock) disable iff (sys_rst)
    mcs_seen |-> (mcs_gap <= EMBS_PH_LAST) &&
      (!machine_cycle_start || mcs_gap == EMBS_PH_LAST))
    else $error("machine cycle not twelve periods");
  chk_ale_period: assert property (@(posedge clock) disable iff (sys_rst || core_rst)
    ($rose(address_latch_strobe) && mode == EMBS_IDLE && !aux_latch_off)
    |-> ##6 (address_latch_strobe || mode != EMBS_IDLE || aux_latch_off))
    else $error("latch strobe not at one sixth rate");
  chk_ale_gated: assert property (@(posedge clock) disable iff (sys_rst || core_rst)
    (aux_latch_off && mode == EMBS_IDLE && $past(mode) == EMBS_IDLE)
    |-> !address_latch_strobe)
    else $error("latch strobe while disabled");
  chk_ale_data_one: assert property (@(posedge clock) disable iff (sys_rst || core_rst)
    (mode != EMBS_IDLE && phase >= EMBS_ALE0_OFF) |-> !address_latch_strobe)
    else $error("second latch pulse in data cycle");
  chk_pf_skip: assert property (@(posedge clock) disable iff (sys_rst || core_rst)
    (mode != EMBS_IDLE) |-> program_fetch_strobe_n)
    else $error("fetch strobe during data access");
  chk_pf_internal: assert property (@(posedge clock) disable iff (sys_rst || core_rst)
    !$past(ext_code) && !$past(ext_code, 2) |-> program_fetch_strobe_n)
    else $error("fetch strobe on internal fetch");
  chk_pf_twice: assert property (@(posedge clock) disable iff (sys_rst || core_rst)
    (machine_cycle_start && mode == EMBS_IDLE && ext_code && $stable(ext_code))
    |-> ##6 !program_fetch_strobe_n [*2])
    else $error("fetch strobe missing");
  chk_rd_strobe: assert property (@(posedge clock) disable iff (sys_rst || core_rst)
    (!data_read_strobe_n) |-> (mode == EMBS_RD) && data_write_strobe_n)
    else $error("read strobe outside read cycle");
  chk_wr_strobe: assert property (@(posedge clock) disable iff (sys_rst || core_rst)
    (mode == EMBS_WR && phase == EMBS_DS_ON)
    |-> !data_write_strobe_n [*8] ##1 data_write_strobe_n)
    else $error("write strobe width wrong");
  chk_ale_on: assert property (@(posedge clock) disable iff (sys_rst || core_rst)
    (mode != EMBS_IDLE && phase == EMBS_ALE0_ON && $past(mode) == mode)
    |-> ##1 address_latch_strobe)
    else $error("no latch pulse for data address");

  cov_read: cover property (@(posedge clock) !data_read_strobe_n);
  cov_write: cover property (@(posedge clock) !data_write_strobe_n);
  cov_gated: cover property (@(posedge clock) aux_latch_off && mode != EMBS_IDLE);
  cov_fetch: cover property (@(posedge clock) !program_fetch_strobe_n);
endmodule

//--- sim/embs_mem_model.sv
/*
  Far-side model: address latch, program memory and data memory,
  reduced to counters of the strobes that they see.
  Assumes the strobes change only just after clock edges.
*/
`timescale 1ns/10ps
module embs_mem_model (
  input wire logic clock,
  input wire logic address_latch_strobe,
  input wire logic program_fetch_strobe_n,
  input wire logic data_read_strobe_n,
  input wire logic data_write_strobe_n,
  output int latch_count,
  output int fetch_count,
  output int read_clocks,
  output int write_clocks
);
  logic ale_q = 1'b0;
  logic pf_q = 1'b1;
  // Latch and program memory count per pulse start, data memories count strobe time
  always @(posedge clock)
  begin
    if (address_latch_strobe === 1'b1 && ale_q === 1'b0) latch_count <= latch_count + 1;
    if (program_fetch_strobe_n === 1'b0 && pf_q === 1'b1) fetch_count <= fetch_count + 1;
    if (data_read_strobe_n === 1'b0) read_clocks <= read_clocks + 1;
    if (data_write_strobe_n === 1'b0) write_clocks <= write_clocks + 1;
    ale_q <= address_latch_strobe;
    pf_q <= program_fetch_strobe_n;
  end
endmodule

//--- sim/test_embs_top.sv
/*
  Self-checking bench for the strobe generator with a counting memory model.
  Assumes the package timing windows and a 24-clock reset qualification.
*/
`timescale 1ns/10ps
module test_embs_top;
  import embs_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic reset_pin = 1'b0;
  logic external_fetch_select = 1'b0;
  logic fetch_internal = 1'b0;
  logic aux_latch_off = 1'b0;
  logic data_move_req = 1'b0;
  logic data_move_write = 1'b0;
  logic core_rst, ale, pf_n, rd_n, wr_n, mcs;
  int n_ale, n_pf, n_rd, n_wr;
  int fail_count = 0;
  int checks_done = 0;
  initial forever #2.5 clock = ~clock;
  embs_top i_embs_top (.clock(clock), .sys_rst(sys_rst), .reset_pin(reset_pin),
    .external_fetch_select(external_fetch_select), .fetch_internal(fetch_internal),
    .aux_latch_off(aux_latch_off), .data_move_req(data_move_req),
    .data_move_write(data_move_write), .core_rst(core_rst), .address_latch_strobe(ale),
    .program_fetch_strobe_n(pf_n), .data_read_strobe_n(rd_n), .data_write_strobe_n(wr_n),
    .machine_cycle_start(mcs));
  embs_mem_model i_embs_mem_model (.clock(clock), .address_latch_strobe(ale),
    .program_fetch_strobe_n(pf_n), .data_read_strobe_n(rd_n), .data_write_strobe_n(wr_n),
    .latch_count(n_ale), .fetch_count(n_pf), .read_clocks(n_rd), .write_clocks(n_wr));
  // Compare and count
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n)
    begin
      @(posedge clock);
      #1;
    end
  endtask
  // Bounded wait for the start of a machine cycle
  task sync_cycle;
    int i;
    for (i = 0; i < 30 && mcs !== 1'b1; i++) tick(1);
    if (i == 30)
    begin
      check("cycle start", 0, 1);
      report_and_stop;
    end
  endtask
  task request(input logic wr);
    data_move_req = 1'b1;
    data_move_write = wr;
    tick(1);
    data_move_req = 1'b0;
  endtask
  // Count strobes over n clocks, optionally requesting a move at the start
  task measure(input int n, input int req, input int ea, input int ep, input int er,
               input int ew);
    int a, p, r, w;
    a = n_ale;
    p = n_pf;
    r = n_rd;
    w = n_wr;
    if (req >= 0) request(req[0]);
    tick(n - (req >= 0));
    check("latch pulses", n_ale - a, ea);
    check("fetch pulses", n_pf - p, ep);
    check("read clocks", n_rd - r, er);
    check("write clocks", n_wr - w, ew);
  endtask
  task test_reset;
    reset_pin = 1'b1;
    tick(20);
    check("core_rst early", core_rst, 1'b0);
    tick(8);
    check("core_rst held", core_rst, 1'b1);
    measure(12, -1, 0, 0, 0, 0);
    reset_pin = 1'b0;
    tick(2);
    check("core_rst off", core_rst, 1'b0);
    $display("test_reset done");
  endtask
  task test_fetch;
    sync_cycle;
    measure(24, -1, 4, 4, 0, 0);
    external_fetch_select = 1'b1;
    fetch_internal = 1'b1;
    tick(1);
    sync_cycle;
    measure(24, -1, 4, 0, 0, 0);
    external_fetch_select = 1'b0;
    tick(1);
    sync_cycle;
    measure(24, -1, 4, 4, 0, 0);
    fetch_internal = 1'b0;
    $display("test_fetch done");
  endtask
  task test_moves;
    sync_cycle;
    request(1'b0);
    sync_cycle;
    measure(24, -1, 3, 2, 8, 0);
    sync_cycle;
    request(1'b1);
    sync_cycle;
    measure(24, 0, 2, 0, 8, 8);
    aux_latch_off = 1'b1;
    sync_cycle;
    measure(24, -1, 0, 4, 0, 0);
    sync_cycle;
    measure(24, 1, 1, 2, 0, 8);
    aux_latch_off = 1'b0;
    $display("test_moves done");
  endtask
  initial
  begin
    tick(6);
    sys_rst = 1'b0;
    tick(2);
    test_reset;
    test_fetch;
    test_moves;
    report_and_stop;
  end
endmodule
